// >>> pkg/bsdp_pkg.sv
package bsdp_pkg;
   // register indices; byte address is four times the index
   localparam logic [31:0] IDX_TLEN = 32'hFFFFF36F;
   localparam logic [31:0] IDX_DATA = 32'h0FFFF370;
   localparam logic [31:0] IDX_FSC = 32'hFFFFF371;
   localparam logic [31:0] IDX_CSR = 32'hFFFFF380;
   localparam int DEC_W = 10;

   localparam logic [7:0] TLEN_RST = 8'h01;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [7:0] FSC_RST = 8'h00;
   localparam logic [7:0] STATUS_TLEN = 8'h01;
   localparam logic [11:0] LOCK_RST = 12'h000;

   localparam logic [3:0] CC_STATUS = 4'h0;
   localparam logic [3:0] CC_LADDR_LO = 4'h4;
   localparam logic [3:0] CC_LADDR_HI = 4'h5;
   localparam logic [3:0] CC_STAT_UNLOCK = 4'h6;

   localparam logic [1:0] FS_SLV_RX = 2'h0;
   localparam logic [1:0] FS_SLV_TX = 2'h1;
   localparam logic [1:0] FS_MST_RX = 2'h2;
   localparam logic [1:0] FS_MST_TX = 2'h3;

   // control/status word bit positions
   localparam int CSR_STATUS_REQUEST_FLAG = 0;
   localparam int CSR_UNDERRUN = 1;
   localparam int CSR_OVERRUN = 2;
   localparam int CSR_NACKERR = 3;
   localparam int CSR_LOCKED = 4;
   localparam int CSR_TXFULL = 5;
   localparam int CSR_RXFULL = 6;
   localparam int CSR_LADDR_LSB = 16;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic valid;
      logic [3:0] code;
      logic [11:0] master;
   } bsdp_ctrl_t;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
      logic parity_ok;
   } bsdp_byte_t;

   typedef struct packed {
      logic req;
      logic last;
      logic frame_last;
      logic nack;
   } bsdp_txev_t;
endpackage

// >>> rtl/bsdp_top.sv
`timescale 1ns/10ps
`default_nettype none
module bsdp_top
   import bsdp_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire bsdp_ctrl_t ctrl_in,
   output logic ctrl_nack,
   input wire logic ack_bit_end,
   input wire logic [11:0] frame_master,
   input wire logic lock_set,
   input wire logic start_evt,
   input wire logic end_evt,
   input wire logic frame_end_evt,
   input wire bsdp_byte_t tlen_rx,
   output logic [7:0] tlen_tx,
   input wire bsdp_txev_t tx_ev,
   input wire logic tx_shift,
   output logic tx_bit,
   input wire bsdp_byte_t rx_in,
   input wire logic broadcast,
   input wire logic rx_frame_last,
   output logic rx_nack,
   input wire logic is_master,
   input wire logic is_tx,
   input wire logic in_len_data,
   input wire logic third_party,
   output logic status_request_flag,
   output logic byte_transfer_irq,
   output logic status_event_irq,
   output logic comm_error_irq,
   output logic combined_event_irq,
   output logic terminate
);
   // ---------------- lock and control-field decision
   logic locked_q, locked_d;
   logic [11:0] lock_addr_q, lock_addr_d;
   wire owner = locked_q && (ctrl_in.master == lock_addr_q);
   wire other = locked_q && (frame_master != lock_addr_q);
   wire c_st = ctrl_in.code == CC_STATUS;
   wire c_lo = ctrl_in.code == CC_LADDR_LO;
   wire c_hi = ctrl_in.code == CC_LADDR_HI;
   wire c_un = ctrl_in.code == CC_STAT_UNLOCK;
   wire c_any = c_st || c_lo || c_hi || c_un;
   wire ack_unl = !locked_q && (c_st || c_un);
   wire nak_unl = !locked_q && (c_lo || c_hi);
   wire ack_own = owner && c_any;
   wire ack_oth = locked_q && !owner && (c_st || c_lo || c_hi);
   wire nak_oth = locked_q && !owner && c_un;
   wire st_acc = ctrl_in.valid && (ack_unl || ack_own || ack_oth);
   wire st_ref = ctrl_in.valid && (nak_unl || nak_oth);
   wire unlock = st_acc && c_un && owner;
   assign ctrl_nack = c_any && (nak_unl || nak_oth);

   always_comb begin
      locked_d = locked_q;
      lock_addr_d = lock_addr_q;
      if (unlock) begin
         locked_d = 1'b0;
      end
      if (lock_set) begin
         locked_d = 1'b1;
         lock_addr_d = frame_master;
      end
   end

   // ---------------- register bus
   logic aw_full_q, w_full_q, bvalid_q, rvalid_q;
   logic [31:0] awaddr_q, wdata_q, rdata_q;
   logic [3:0] wstrb_q;
   logic [1:0] bresp_q, rresp_q;
   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take = s_axi_wvalid && s_axi_wready;
   wire ar_take = s_axi_arvalid && s_axi_arready;
   assign s_axi_awready = !aw_full_q && !bvalid_q;
   assign s_axi_wready = !w_full_q && !bvalid_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rdata = rdata_q;
   wire do_wr = aw_full_q && w_full_q;
   wire [DEC_W-1:0] wsel = awaddr_q[DEC_W+1:2];
   wire [DEC_W-1:0] rsel = s_axi_araddr[DEC_W+1:2];
   wire wr_tlen = do_wr && wsel == IDX_TLEN[DEC_W-1:0] && wstrb_q[0];
   wire wr_data = do_wr && wsel == IDX_DATA[DEC_W-1:0] && wstrb_q[0];
   wire wr_csr = do_wr && wsel == IDX_CSR[DEC_W-1:0] && wstrb_q[0];
   wire w_hit = (wsel == IDX_TLEN[DEC_W-1:0])
      || (wsel == IDX_DATA[DEC_W-1:0])
      || (wsel == IDX_CSR[DEC_W-1:0]);
   wire r_tlen = rsel == IDX_TLEN[DEC_W-1:0];
   wire r_data = rsel == IDX_DATA[DEC_W-1:0];
   wire r_fsc = rsel == IDX_FSC[DEC_W-1:0];
   wire r_csr = rsel == IDX_CSR[DEC_W-1:0];
   wire r_hit = r_tlen || r_data || r_fsc || r_csr;
   wire rd_data = ar_take && r_data;

   // ---------------- data path registers
   logic [7:0] tlen_wr_q, tlen_rd_q, tx_hold_q, tx_save_q, tx_sh_q;
   logic [7:0] tx_hold_d, rx_q, fsc_q, fsc_d;
   logic tx_full_q, tx_full_d, rx_full_q, rx_full_d;
   logic stf_q, stf_d, unr_q, unr_d, ovr_q, ovr_d, nke_q, nke_d;
   logic nak_pend_q, reply_q, reply_d;
   logic bti_q, sti_q, eri_q, term_q;
   logic [7:0] tx_sh_d;

   wire [31:0] csr_rd = {4'h0, lock_addr_q, 9'h000, rx_full_q,
      tx_full_q, locked_q, nke_q, ovr_q, unr_q, stf_q};
   wire [31:0] rd_mux = r_tlen ? {24'h0, tlen_rd_q} :
      r_data ? {24'h0, rx_q} :
      r_fsc ? {24'h0, fsc_q} :
      r_csr ? csr_rd : 32'h0;

   // ---------------- transmit
   wire tx_load = tx_ev.req && !tx_ev.nack && tx_full_q;
   wire tx_undr = tx_ev.req && !tx_ev.nack && !tx_full_q;
   wire tx_retx = tx_ev.req && tx_ev.nack;
   wire tx_irq = tx_load && !tx_ev.last && !tx_ev.frame_last;
   wire lad_load = st_acc && (c_lo || c_hi);
   wire [7:0] lad_byte = c_lo ? lock_addr_q[7:0] :
      {lock_addr_q[11:8], 4'h0};
   assign tx_bit = tx_sh_q[7];

   always_comb begin
      tx_sh_d = tx_sh_q;
      if (tx_load) begin
         tx_sh_d = tx_hold_q;
      end else if (tx_retx) begin
         tx_sh_d = tx_save_q;
      end else if (tx_shift) begin
         tx_sh_d = {tx_sh_q[6:0], 1'b0};
      end
   end

   always_comb begin
      tx_hold_d = tx_hold_q;
      tx_full_d = tx_full_q;
      if (tx_load) begin
         tx_full_d = 1'b0;
      end
      if (lad_load) begin
         tx_hold_d = lad_byte;
         tx_full_d = 1'b1;
      end else if (wr_data) begin
         tx_hold_d = wdata_q[7:0];
         tx_full_d = 1'b1;
      end
   end

   // ---------------- receive
   wire rx_good = rx_in.valid && rx_in.parity_ok;
   wire rx_busy = rx_full_q && !rd_data;
   wire rx_store = rx_good && !rx_busy;
   wire rx_ovr = rx_good && rx_busy && broadcast;
   wire rx_refuse = rx_good && rx_busy && !broadcast;
   wire rx_fe_err = rx_refuse && rx_frame_last;
   assign rx_nack = rx_in.valid && rx_busy && !broadcast;

   always_comb begin
      rx_full_d = rx_full_q;
      if (rd_data) begin
         rx_full_d = 1'b0;
      end
      if (rx_store) begin
         rx_full_d = 1'b1;
      end
   end

   // ---------------- flags, set wins over software clear
   wire nak_fire = nak_pend_q && ack_bit_end;
   wire [31:0] clr = wr_csr ? wdata_q : 32'h0;
   always_comb begin
      stf_d = stf_q && !clr[CSR_STATUS_REQUEST_FLAG];
      unr_d = unr_q && !clr[CSR_UNDERRUN];
      ovr_d = ovr_q && !clr[CSR_OVERRUN];
      nke_d = nke_q && !clr[CSR_NACKERR];
      if (st_acc) begin
         stf_d = 1'b1;
      end
      if (tx_undr) begin
         unr_d = 1'b1;
      end
      if (rx_ovr) begin
         ovr_d = 1'b1;
      end
      if (nak_fire || rx_fe_err) begin
         nke_d = 1'b1;
      end
   end

   // ---------------- interrupt events
   wire se_ok = (start_evt || end_evt) && !other;
   wire ev_sta = st_acc || se_ok || frame_end_evt;
   wire ev_err = tx_undr || rx_ovr || nak_fire || rx_fe_err;
   wire ev_byte = tx_irq || rx_store;
   wire ev_any = ev_sta || ev_err || ev_byte;

   wire [1:0] fstate = is_master ?
      ((in_len_data && !is_tx) ? FS_MST_RX : FS_MST_TX) :
      ((in_len_data && is_tx) ? FS_SLV_TX : FS_SLV_RX);

   always_comb begin
      fsc_d = fsc_q;
      if (ev_any) begin
         fsc_d = third_party ? FSC_RST : {6'h00, fstate};
      end
   end

   always_comb begin
      reply_d = reply_q;
      if (end_evt || term_q) begin
         reply_d = 1'b0;
      end
      if (st_acc) begin
         reply_d = 1'b1;
      end
   end
   assign tlen_tx = reply_q ? STATUS_TLEN : tlen_wr_q;

   assign status_request_flag = stf_q;
   assign byte_transfer_irq = bti_q;
   assign status_event_irq = sti_q;
   assign comm_error_irq = eri_q;
   assign combined_event_irq = sti_q || eri_q;
   assign terminate = term_q;

   // ---------------- bus slave state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         awaddr_q <= 32'h0;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
      end else begin
         if (aw_take) begin
            aw_full_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (w_take) begin
            w_full_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (do_wr) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= w_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0;
         rresp_q <= RESP_OKAY;
      end else if (ar_take) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_mux;
         rresp_q <= r_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // ---------------- block state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tlen_wr_q <= TLEN_RST;
         tlen_rd_q <= TLEN_RST;
      end else begin
         if (wr_tlen) begin
            tlen_wr_q <= wdata_q[7:0];
         end
         if (tlen_rx.valid && tlen_rx.parity_ok) begin
            tlen_rd_q <= tlen_rx.data;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_hold_q <= DATA_RST;
         tx_full_q <= 1'b0;
         tx_sh_q <= DATA_RST;
         tx_save_q <= DATA_RST;
      end else begin
         tx_hold_q <= tx_hold_d;
         tx_full_q <= tx_full_d;
         tx_sh_q <= tx_sh_d;
         if (tx_load) begin
            tx_save_q <= tx_hold_q;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_q <= DATA_RST;
         rx_full_q <= 1'b0;
      end else begin
         rx_full_q <= rx_full_d;
         if (rx_store) begin
            rx_q <= rx_in.data;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         locked_q <= 1'b0;
         lock_addr_q <= LOCK_RST;
         stf_q <= 1'b0;
         unr_q <= 1'b0;
         ovr_q <= 1'b0;
         nke_q <= 1'b0;
         fsc_q <= FSC_RST;
         reply_q <= 1'b0;
      end else begin
         locked_q <= locked_d;
         lock_addr_q <= lock_addr_d;
         stf_q <= stf_d;
         unr_q <= unr_d;
         ovr_q <= ovr_d;
         nke_q <= nke_d;
         fsc_q <= fsc_d;
         reply_q <= reply_d;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         nak_pend_q <= 1'b0;
         bti_q <= 1'b0;
         sti_q <= 1'b0;
         eri_q <= 1'b0;
         term_q <= 1'b0;
      end else begin
         if (st_ref) begin
            nak_pend_q <= 1'b1;
         end else if (ack_bit_end) begin
            nak_pend_q <= 1'b0;
         end
         bti_q <= ev_byte;
         sti_q <= ev_sta;
         eri_q <= ev_err;
         term_q <= nak_fire || tx_undr;
      end
   end
endmodule
`default_nettype wire

// >>> test/bsdp_bus_model.sv
`timescale 1ns/10ps
`default_nettype none
module bsdp_bus_model
   import bsdp_pkg::*;
(
   input wire logic aclk,
   input wire logic ctrl_nack,
   input wire logic rx_nack,
   output var bsdp_ctrl_t ctrl_in,
   output logic ack_bit_end,
   output logic [11:0] frame_master,
   output logic lock_set,
   output logic end_evt,
   output var bsdp_byte_t tlen_rx,
   output var bsdp_txev_t tx_ev,
   output logic tx_shift,
   output var bsdp_byte_t rx_in
);
   initial begin
      ctrl_in = '0;
      tlen_rx = '0;
      tx_ev = '0;
      rx_in = '0;
      frame_master = '0;
      {end_evt, tx_shift, lock_set, ack_bit_end} = '0;
   end
   task automatic ctrl(input logic [3:0] c, input logic [11:0] m,
      output logic nk);
      @(posedge aclk);
      frame_master <= m;
      ctrl_in <= '{1'b1, c, m};
      #1 nk = ctrl_nack;
      @(posedge aclk);
      ctrl_in <= '{1'b0, ~c, ~m};
   endtask
   task automatic ev(input int k);
      @(posedge aclk);
      {end_evt, tx_shift, lock_set, ack_bit_end} <= 4'h1 << k;
      @(posedge aclk);
      {end_evt, tx_shift, lock_set, ack_bit_end} <= 4'h0;
   endtask
   // bytes are requested whether or not the host kept up
   task automatic txreq(input logic [2:0] f);
      @(posedge aclk);
      tx_ev <= {1'b1, f};
      @(posedge aclk);
      tx_ev <= '0;
   endtask
   // k 0 data field, 1 length field; sent whether or not read
   task automatic byt(input int k, input logic [7:0] d, input logic ok,
      output logic nk);
      @(posedge aclk);
      if (k == 0) rx_in <= {1'b1, d, ok};
      else tlen_rx <= {1'b1, d, ok};
      #1 nk = rx_nack;
      @(posedge aclk);
      rx_in <= {1'b0, ~d, 1'b0};
      tlen_rx <= {1'b0, ~d, 1'b0};
   endtask
endmodule
`default_nettype wire

// >>> test/bsdp_props.sv
`timescale 1ns/10ps
`default_nettype none
module bsdp_props
   import bsdp_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_bvalid,
   input wire bsdp_ctrl_t ctrl_in,
   input wire logic ctrl_nack,
   input wire logic ack_bit_end,
   input wire bsdp_txev_t tx_ev,
   input wire bsdp_byte_t rx_in,
   input wire logic broadcast,
   input wire logic rx_nack,
   input wire logic [7:0] tlen_tx,
   input wire logic status_request_flag,
   input wire logic byte_transfer_irq,
   input wire logic status_event_irq,
   input wire logic comm_error_irq,
   input wire logic combined_event_irq,
   input wire logic terminate
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic pend_q;
   wire logic stat_w = ctrl_in.code inside {CC_STATUS, CC_LADDR_LO,
      CC_LADDR_HI, CC_STAT_UNLOCK};
   // refused request waiting for its acknowledge bit
   always_ff @(posedge aclk) begin
      if (!aresetn || ack_bit_end) begin
         pend_q <= 1'b0;
      end
      else if (ctrl_in.valid && ctrl_nack) begin
         pend_q <= 1'b1;
      end
   end
   sequence s_acc;
      ctrl_in.valid && stat_w && !ctrl_nack;
   endsequence
   sequence s_ref;
      ctrl_in.valid && ctrl_nack;
   endsequence
   AST_STAT_ACK: assert property (s_acc |=> status_event_irq
      && status_request_flag) else $error("status irq missing");
   AST_STAT_REF: assert property (s_ref |=> !status_event_irq)
      else $error("status irq on refusal");
   AST_NACK_ERR: assert property (ack_bit_end && pend_q |=>
      comm_error_irq && terminate) else $error("refusal not ended");
   AST_REPLY_LEN: assert property (s_acc |=> tlen_tx == 8'h01)
      else $error("reply length not one");
   AST_TX_NOIRQ: assert property (tx_ev.req && !rx_in.valid &&
      (tx_ev.nack || tx_ev.last || tx_ev.frame_last) |=>
      !byte_transfer_irq) else $error("byte irq on final or resend");
   AST_RX_BAD: assert property (rx_in.valid && !rx_in.parity_ok &&
      !tx_ev.req |=> !byte_transfer_irq) else $error("bad byte irq");
   AST_BCAST: assert property (broadcast |-> !rx_nack)
      else $error("nack in broadcast");
   AST_RX_NACK: assert property (rx_nack && !tx_ev.req |=>
      !byte_transfer_irq) else $error("byte irq on unread");
   AST_COMBINED: assert property (status_event_irq || comm_error_irq
      |-> combined_event_irq) else $error("combined irq missing");
   // a clear lands on the edge that raises the write response
   AST_STICKY: assert property (status_request_flag |=>
      status_request_flag || s_axi_bvalid) else $error("status flag lost");
   AST_TERM: assert property (terminate |-> comm_error_irq &&
      ($past(ack_bit_end) || $past(tx_ev.req))) else $error("bad stop");
endmodule
bind bsdp_top bsdp_props bsdp_props_i (.*);
`default_nettype wire

// >>> test/tb_bsdp_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_bsdp_top;
   import bsdp_pkg::*;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, ctrl_nack, tx_bit;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic ack_bit_end, lock_set, start_evt, end_evt, frame_end_evt, nk;
   logic tx_shift, broadcast, rx_frame_last, rx_nack, is_master, is_tx;
   logic in_len_data, third_party, status_request_flag, terminate;
   logic byte_transfer_irq, status_event_irq, comm_error_irq;
   logic combined_event_irq;
   logic [11:0] frame_master;
   logic [7:0] tlen_tx;
   logic [31:0] d;
   bsdp_ctrl_t ctrl_in;
   bsdp_byte_t tlen_rx, rx_in;
   bsdp_txev_t tx_ev;
   int n_fail, checks_done, cyc;
   bsdp_top bsdp_top_i (.*);
   bsdp_bus_model bsdp_bus_model_i (.*);
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_fail++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end
      else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected at %0t: got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [31:0] i, input logic [31:0] v);
      @(posedge aclk);
      s_axi_awaddr <= {i[29:0], 2'b00};
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      fork
         begin
            #1;
            while (!s_axi_awready) @(posedge aclk) #1;
            @(posedge aclk);
            s_axi_awvalid <= 1'b0;
         end
         begin
            #1;
            while (!s_axi_wready) @(posedge aclk) #1;
            @(posedge aclk);
            s_axi_wvalid <= 1'b0;
         end
      join
      #1;
      while (!s_axi_bvalid) @(posedge aclk) #1;
      r = s_axi_bresp;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] i);
      @(posedge aclk);
      s_axi_araddr <= {i[29:0], 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      #1;
      while (!s_axi_arready) @(posedge aclk) #1;
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      #1;
      while (!s_axi_rvalid) @(posedge aclk) #1;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask
   task automatic lv(input logic [5:0] v);
      @(posedge aclk);
      broadcast <= v[5];
      rx_frame_last <= v[4];
      is_master <= v[3];
      is_tx <= v[2];
      third_party <= v[1];
      in_len_data <= v[0];
   endtask
   task automatic pulse(input logic s, input logic f);
      @(posedge aclk);
      start_evt <= s;
      frame_end_evt <= f;
      @(posedge aclk);
      start_evt <= 1'b0;
      frame_end_evt <= 1'b0;
      #1;
   endtask
   task automatic t_reset();
      rd(IDX_TLEN);
      chk(d, 32'h01);
      rd(IDX_DATA);
      chk(d, 32'h00);
      rd(IDX_FSC);
      chk(d, 32'h00);
      rd(32'h40);
      chk(r, RESP_SLVERR);
      wr(32'h40, 32'h0);
      chk(r, RESP_SLVERR);
      $display("t_reset done");
   endtask
   task automatic t_ctrl();
      // {end irq, refused, code, master}
      logic [17:0] tab [13] = '{18'h20123, 18'h26123, 18'h14123,
         18'h15123, 18'h20123, 18'h24123, 18'h25123, 18'h00456, 18'h04456,
         18'h05456, 18'h16456, 18'h26123, 18'h14456};
      wr(IDX_TLEN, 32'h00);
      foreach (tab[k]) begin
         if (k == 4) begin
            bsdp_bus_model_i.ev(1);
            rd(IDX_CSR);
            chk(d & 32'h0FFF0010, 32'h01230010);
         end
         bsdp_bus_model_i.ctrl(tab[k][15:12], tab[k][11:0], nk);
         #1;
         chk(nk, tab[k][16]);
         chk(status_event_irq, !tab[k][16]);
         if (tab[k][16]) begin
            bsdp_bus_model_i.ev(0);
            #1;
            chk({comm_error_irq, terminate}, 2'b11);
         end
         else begin
            chk({status_request_flag, tlen_tx}, 9'h101);
            bsdp_bus_model_i.ev(3);
            #1;
            chk(status_event_irq, tab[k][17]);
            pulse(1'b1, 1'b0);
            chk(status_event_irq, tab[k][17]);
         end
      end
      wr(IDX_CSR, 32'hF);
      rd(IDX_CSR);
      chk(d & 32'hF, 32'h0);
      $display("t_ctrl done");
   endtask
   task automatic t_tx();
      logic [7:0] b = 8'hA5;
      chk(tlen_tx, 8'h00);
      lv(6'b000101);
      rd(IDX_TLEN);
      chk(d, 32'h01);
      wr(IDX_DATA, 32'hA5);
      rd(IDX_DATA);
      chk(d, 32'h00);
      bsdp_bus_model_i.txreq(3'b000);
      #1;
      chk(byte_transfer_irq, 1'b1);
      rd(IDX_FSC);
      chk(d, 32'h01);
      for (int i = 7; i >= 0; i--) begin
         chk(tx_bit, b[i]);
         bsdp_bus_model_i.ev(2);
         #1;
      end
      bsdp_bus_model_i.txreq(3'b001);
      #1;
      chk({byte_transfer_irq, tx_bit}, 2'b01);
      wr(IDX_DATA, 32'h3C);
      bsdp_bus_model_i.txreq(3'b100);
      #1;
      chk({byte_transfer_irq, tx_bit}, 2'b00);
      wr(IDX_DATA, 32'h80);
      bsdp_bus_model_i.txreq(3'b010);
      #1;
      chk({byte_transfer_irq, tx_bit}, 2'b01);
      bsdp_bus_model_i.txreq(3'b000);
      #1;
      chk({comm_error_irq, terminate, byte_transfer_irq,
         combined_event_irq}, 4'b1101);
      rd(IDX_CSR);
      chk(d & 32'h2, 32'h2);
      $display("t_tx done");
   endtask
   task automatic t_rx();
      lv(6'b001001);
      bsdp_bus_model_i.byt(1, 8'h20, 1'b0, nk);
      rd(IDX_TLEN);
      chk(d, 32'h01);
      bsdp_bus_model_i.byt(1, 8'h20, 1'b1, nk);
      rd(IDX_TLEN);
      chk(d, 32'h20);
      bsdp_bus_model_i.byt(0, 8'h5A, 1'b1, nk);
      #1;
      chk(byte_transfer_irq, 1'b1);
      rd(IDX_FSC);
      chk(d, 32'h02);
      bsdp_bus_model_i.byt(0, 8'hC3, 1'b1, nk);
      chk(nk, 1'b1);
      rd(IDX_DATA);
      chk(d, 32'h5A);
      bsdp_bus_model_i.byt(0, 8'hC3, 1'b0, nk);
      #1;
      chk(byte_transfer_irq, 1'b0);
      lv(6'b101100);
      bsdp_bus_model_i.byt(0, 8'h11, 1'b1, nk);
      rd(IDX_FSC);
      chk(d, 32'h03);
      lv(6'b100010);
      bsdp_bus_model_i.byt(0, 8'h22, 1'b1, nk);
      #1;
      chk(comm_error_irq, 1'b1);
      rd(IDX_FSC);
      chk(d, 32'h00);
      lv(6'b010000);
      // frame end from the engine lands with the refused byte
      fork
         bsdp_bus_model_i.byt(0, 8'h33, 1'b1, nk);
         pulse(1'b0, 1'b1);
      join
      chk({nk, comm_error_irq, status_event_irq}, 3'b111);
      rd(IDX_CSR);
      chk(d & 32'hC, 32'hC);
      $display("t_rx done");
   endtask
   initial begin
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
      s_axi_wstrb = 4'hF;
      {start_evt, frame_end_evt, in_len_data} = '0;
      {broadcast, rx_frame_last, is_master, is_tx, third_party} = '0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_ctrl();
      t_tx();
      t_rx();
      end_of_test();
   end
endmodule
`default_nettype wire
